// >>> design/pptg_top.sv
// Top of the pulse generator: single-channel generators and one three-phase unit
`timescale 1ns/100ps
// Contract
// - Enable drives enable_n low, else silent
// - Duty is value over scale, clipped
// - Four output types select both outputs
// - Output type may change while running
// - Offset mode maps minus one..one onto 0..100%
// - Shared PWM frequency, default 20 kHz
// - Too high frequency clipped to maximum
// - PDM decides pulse or space per slot
// - Three-phase: six drives, enable, fault input
// - Phase duty commanded, zero means 50%
// - Disabled three-phase holds all drives low
// - Fault latches until enable rises again
// - Dead time taken from each edge
// - Fault polarity setting selects active level
// - Three-phase scale sets command half-range
module pptg_top (
    input  logic                                        core_clk,
    input  logic                                        sys_rst,
    input  pptg_pkg::pptg_cfg_t                         cfg,
    input  pptg_pkg::pptg_ch_cmd_t [pptg_pkg::NCH-1:0]  ch_cmd,
    output pptg_pkg::pptg_ch_out_t [pptg_pkg::NCH-1:0]  ch_out,
    input  pptg_pkg::pptg_tp_cmd_t                      tp_cmd,
    input  logic                                        tp_fault_pin,
    output pptg_pkg::pptg_tp_out_t                      tp_out
);
    localparam int NCH = pptg_pkg::NCH;

    typedef struct packed {
        logic [pptg_pkg::PH_W-1:0]           pwm_ph;
        logic [pptg_pkg::PH_W-1:0]           pdm_ph;
        logic                                pwm_tick;
        logic                                pdm_tick;
        logic [pptg_pkg::PWMHZ_W-1:0]        pwm_hz;
        pptg_pkg::pptg_duty_t [NCH-1:0]      lat;
        logic [NCH-1:0][17:0]                acc;
        logic [NCH-1:0]                      pdm_bit;
        pptg_pkg::pptg_ch_out_t [NCH-1:0]    out;
    } pptg_top_st_t;

    pptg_top_st_t                   st_r;
    pptg_top_st_t                   st_nxt;
    logic [pptg_pkg::PWMHZ_W-1:0]   pwm_hz;
    logic [pptg_pkg::PH_W-1:0]      pdm_hz;

    // clip to the highest supported rate
    always_comb begin
        if (cfg.pwm_hz == '0) begin
            pwm_hz = pptg_pkg::PWM_DEF_HZ;
        end else if (cfg.pwm_hz > pptg_pkg::PWM_MAX_HZ) begin
            pwm_hz = pptg_pkg::PWM_MAX_HZ;
        end else begin
            pwm_hz = cfg.pwm_hz;
        end
        if (cfg.pdm_hz == '0) begin
            pdm_hz = pptg_pkg::PDM_DEF_HZ;
        end else if (cfg.pdm_hz > pptg_pkg::PDM_MAX_HZ) begin
            pdm_hz = pptg_pkg::PDM_MAX_HZ;
        end else begin
            pdm_hz = cfg.pdm_hz;
        end
    end

    always_comb begin
        logic [pptg_pkg::PH_W:0] sum;
        logic [17:0]             acc_sum;
        logic                    pwm;
        logic                    pdm_mode;
        logic                    dir;
        pptg_pkg::pptg_duty_t    d;
        sum      = '0;
        acc_sum  = '0;
        pwm      = 1'b0;
        pdm_mode = 1'b0;
        dir      = 1'b0;
        d        = '0;
        st_nxt   = st_r;
        sum = {1'b0, st_r.pwm_ph} + (pptg_pkg::PH_W+1)'(st_r.pwm_hz);
        st_nxt.pwm_tick = (sum >= {1'b0, pptg_pkg::CLK_HZ_V});
        st_nxt.pwm_ph = st_nxt.pwm_tick ? pptg_pkg::PH_W'(sum - {1'b0, pptg_pkg::CLK_HZ_V})
                                        : pptg_pkg::PH_W'(sum);
        sum = {1'b0, st_r.pdm_ph} + {1'b0, pdm_hz};
        st_nxt.pdm_tick = (sum >= {1'b0, pptg_pkg::CLK_HZ_V});
        st_nxt.pdm_ph = st_nxt.pdm_tick ? pptg_pkg::PH_W'(sum - {1'b0, pptg_pkg::CLK_HZ_V})
                                        : pptg_pkg::PH_W'(sum);
        // rate swaps at the boundary
        // Phase and dead time then share one rate per period
        if (st_nxt.pwm_tick) begin
            st_nxt.pwm_hz = pwm_hz;
        end
        for (int i = 0; i < NCH; i++) begin
            pdm_mode = (ch_cmd[i].otype == pptg_pkg::PPTG_OT_PDM_DIR);
            d = pptg_pkg::duty(ch_cmd[i].value, ch_cmd[i].scale, ch_cmd[i].offset_mode);
            if (pdm_mode ? st_r.pdm_tick : st_r.pwm_tick) begin
                st_nxt.lat[i] = d;
            end
            if (st_r.pdm_tick) begin
                acc_sum = st_r.acc[i] + 18'(st_r.lat[i].num);
                if (acc_sum >= 18'(st_r.lat[i].den) && st_r.lat[i].den != '0) begin
                    st_nxt.pdm_bit[i] = 1'b1;
                    st_nxt.acc[i] = acc_sum - 18'(st_r.lat[i].den);
                end else begin
                    st_nxt.pdm_bit[i] = 1'b0;
                    st_nxt.acc[i] = acc_sum;
                end
            end
            pwm = pptg_pkg::under(64'(st_r.pwm_ph), st_r.lat[i].den, st_r.lat[i].num, 64'h0);
            dir = st_r.lat[i].dir;
            unique case (ch_cmd[i].otype)
                pptg_pkg::PPTG_OT_PWM_DIR: begin
                    st_nxt.out[i].first_signal_output  = pwm;
                    st_nxt.out[i].second_signal_output = dir;
                end
                pptg_pkg::PPTG_OT_UP_DOWN: begin
                    st_nxt.out[i].first_signal_output  = pwm && !dir;
                    st_nxt.out[i].second_signal_output = pwm && dir;
                end
                pptg_pkg::PPTG_OT_PDM_DIR: begin
                    st_nxt.out[i].first_signal_output  = st_r.pdm_bit[i];
                    st_nxt.out[i].second_signal_output = dir;
                end
                pptg_pkg::PPTG_OT_DIR_PWM: begin
                    st_nxt.out[i].first_signal_output  = dir;
                    st_nxt.out[i].second_signal_output = pwm;
                end
                default: begin
                    st_nxt.out[i].first_signal_output  = 1'b0;
                    st_nxt.out[i].second_signal_output = 1'b0;
                end
            endcase
            st_nxt.out[i].enable_n = !ch_cmd[i].enable;
            if (!ch_cmd[i].enable) begin
                st_nxt.out[i].first_signal_output  = 1'b0;
                st_nxt.out[i].second_signal_output = 1'b0;
                st_nxt.acc[i] = '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.pwm_hz <= pptg_pkg::PWM_DEF_HZ;
            for (int i = 0; i < NCH; i++) begin
                st_r.out[i].enable_n <= 1'b1;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch_out = st_r.out;

    pptg_tpg u_tpg (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pwm_ph    (st_r.pwm_ph),
        .pwm_tick  (st_r.pwm_tick),
        .pwm_hz    (st_r.pwm_hz),
        .cmd       (tp_cmd),
        .fault_pin (tp_fault_pin),
        .out       (tp_out)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_DIS_QUIET: assert property (!ch_cmd[0].enable |=>
        ch_out[0].enable_n && !ch_out[0].first_signal_output && !ch_out[0].second_signal_output)
        else $error("disabled channel not silent");
    AST_EN_LOW: assert property (ch_cmd[1].enable |=> !ch_out[1].enable_n)
        else $error("enabled channel enable_n not low");
    AST_CLIP_HZ: assert property (cfg.pwm_hz > pptg_pkg::PWM_MAX_HZ |->
        pwm_hz == pptg_pkg::PWM_MAX_HZ)
        else $error("pwm rate not clipped");
    AST_TICK_GAP: assert property (st_r.pwm_tick |=> !st_r.pwm_tick [*2])
        else $error("pwm periods too short");
    AST_DUTY_CLIP: assert property (st_r.pwm_tick && ch_cmd[0].otype != 3'h3 &&
        !ch_cmd[0].offset_mode && ch_cmd[0].scale != 16'h0000 &&
        ch_cmd[0].value >= $signed({1'b0, ch_cmd[0].scale}) |=>
        st_r.lat[0].num == st_r.lat[0].den && !st_r.lat[0].dir)
        else $error("duty not clipped to full");
    AST_OFFSET_MID: assert property (st_r.pwm_tick && ch_cmd[0].otype != 3'h3 &&
        ch_cmd[0].offset_mode && ch_cmd[0].value == 16'h0000 |=>
        {st_r.lat[0].num, 1'b0} == {1'b0, st_r.lat[0].den})
        else $error("offset zero not at half duty");
    AST_DIR_PWM: assert property (ch_cmd[0].enable &&
        ch_cmd[0].otype == pptg_pkg::PPTG_OT_DIR_PWM |=>
        ch_out[0].first_signal_output == $past(st_r.lat[0].dir))
        else $error("direction missing on first output");
    AST_UP_DOWN: assert property (ch_cmd[0].otype == pptg_pkg::PPTG_OT_UP_DOWN |=>
        !(ch_out[0].first_signal_output && ch_out[0].second_signal_output))
        else $error("up and down both active");
    AST_HOLD: assert property (!st_r.pwm_tick && ch_cmd[0].otype != 3'h3 |=>
        $stable(st_r.lat[0]))
        else $error("duty changed inside a period");
    AST_PDM_SLOT: assert property (!st_r.pdm_tick |=> $stable(st_r.pdm_bit))
        else $error("pdm changed outside a slot edge");
    COV_PDM: cover property (ch_cmd[0].enable && ch_cmd[0].otype == 3'h3 && st_r.pdm_bit[0]);
    COV_OFFSET: cover property (ch_cmd[0].offset_mode && st_r.pwm_tick);
    COV_TYPE_CHANGE: cover property (ch_cmd[0].enable && $changed(ch_cmd[0].otype));
endmodule // pptg_top

// >>> design/pptg_pkg.sv
// Constants, carrier types and shared functions of the pulse generator block
package pptg_pkg;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned REF_CLK_HZ     = 100_000_000;
    localparam int unsigned REF_PWM_MAX_HZ = 193_000;
    localparam int unsigned PWM_MIN_CYC    =
        (REF_CLK_HZ + REF_PWM_MAX_HZ - 1) / REF_PWM_MAX_HZ;
    localparam int          NCH            = 2;
    localparam int          PH_W           = 25;
    localparam int          PWMHZ_W        = 18;
    localparam logic [PH_W-1:0]    CLK_HZ_V   = PH_W'(CLK_HZ);
    localparam logic [PH_W-1:0]    HALF_V     = PH_W'(CLK_HZ / 2);
    localparam logic [PWMHZ_W-1:0] PWM_MAX_HZ = PWMHZ_W'(CLK_HZ / PWM_MIN_CYC);
    localparam logic [PWMHZ_W-1:0] PWM_DEF_HZ = 18'h04E20;
    localparam logic [PH_W-1:0]    PDM_MAX_HZ = PH_W'(CLK_HZ - 1);
    localparam logic [PH_W-1:0]    PDM_DEF_HZ = 25'h0004E20;
    localparam logic [15:0]        SCALE_ONE  = 16'h0100;
    localparam logic [15:0]        DEAD_DEF_NS = 16'h1388;

    typedef enum logic [2:0] {
        PPTG_OT_PWM_DIR = 3'h1,
        PPTG_OT_UP_DOWN = 3'h2,
        PPTG_OT_PDM_DIR = 3'h3,
        PPTG_OT_DIR_PWM = 3'h4
    } pptg_otype_t;

    typedef struct packed {
        logic [PWMHZ_W-1:0] pwm_hz;
        logic [PH_W-1:0]    pdm_hz;
    } pptg_cfg_t;

    typedef struct packed {
        logic               enable;
        logic               offset_mode;
        logic [2:0]         otype;
        logic signed [15:0] value;
        logic [15:0]        scale;
    } pptg_ch_cmd_t;

    typedef struct packed {
        logic enable_n;
        logic first_signal_output;
        logic second_signal_output;
    } pptg_ch_out_t;

    typedef struct packed {
        logic [16:0] num;
        logic [16:0] den;
        logic        dir;
    } pptg_duty_t;

    typedef struct packed {
        logic             enable;
        logic             fault_invert;
        logic [2:0][15:0] value;
        logic [15:0]      scale;
        logic [15:0]      dead_ns;
    } pptg_tp_cmd_t;

    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
        logic       amp_en;
        logic       fault;
    } pptg_tp_out_t;

    // Duty as num/den, command clipped to plus or minus scale
    function automatic pptg_duty_t duty(input logic signed [15:0] v,
                                        input logic [15:0] sc, input logic offs);
        pptg_duty_t         d;
        logic signed [17:0] s;
        logic signed [17:0] c;
        s = (sc == 16'h0000) ? $signed({2'h0, SCALE_ONE}) : $signed({2'h0, sc});
        c = {{2{v[15]}}, v};
        if (c > s) begin
            c = s;
        end else if (c < -s) begin
            c = -s;
        end
        if (offs) begin
            d.num = 17'(c + s);
            d.den = 17'(s <<< 1);
            d.dir = 1'b0;
        end else begin
            d.num = 17'((c < 0) ? -c : c);
            d.den = 17'(s);
            d.dir = (c < 0);
        end
        return d;
    endfunction

    // True while a position within the period lies under the duty threshold
    function automatic logic under(input logic [63:0] pos, input logic [16:0] den,
                                   input logic [16:0] num, input logic [63:0] extra);
        return (pos * 64'(den)) < (64'(num) * 64'(CLK_HZ) + extra);
    endfunction
endpackage

// >>> design/pptg_tpg.sv
// Three-phase gate generator with dead time and latched fault
`timescale 1ns/100ps
module pptg_tpg (
    input  logic                            core_clk,
    input  logic                            sys_rst,
    input  logic [pptg_pkg::PH_W-1:0]       pwm_ph,
    input  logic                            pwm_tick,
    input  logic [pptg_pkg::PWMHZ_W-1:0]    pwm_hz,
    input  pptg_pkg::pptg_tp_cmd_t          cmd,
    input  logic                            fault_pin,
    output pptg_pkg::pptg_tp_out_t          out
);
    typedef struct packed {
        pptg_pkg::pptg_duty_t [2:0] lat;
        logic [63:0]                dtt;
        logic                       en_d;
        pptg_pkg::pptg_tp_out_t     out;
    } pptg_tp_st_t;

    pptg_tp_st_t st_r;
    pptg_tp_st_t st_nxt;

    always_comb begin
        logic [31:0] dcyc;
        logic [63:0] tri_pos;
        logic        act;
        logic        run;
        dcyc    = '0;
        tri_pos = '0;
        act     = 1'b0;
        run     = 1'b0;
        st_nxt  = st_r;
        dcyc = (32'(cmd.dead_ns) + pptg_pkg::CLK_PERIOD_NS - 1) / pptg_pkg::CLK_PERIOD_NS;
        tri_pos = (pwm_ph < pptg_pkg::HALF_V) ? 64'(pwm_ph) << 1
                : 64'(pptg_pkg::CLK_HZ_V - pwm_ph) << 1;
        if (pwm_tick) begin
            for (int k = 0; k < 3; k++) begin
                st_nxt.lat[k] = pptg_pkg::duty(cmd.value[k], cmd.scale, 1'b1);
            end
            st_nxt.dtt = (64'(dcyc) * 64'(pwm_hz)) << 1;
        end
        act = ~(fault_pin ^ cmd.fault_invert);
        st_nxt.en_d = cmd.enable;
        if (act) begin
            st_nxt.out.fault = 1'b1;
        end else if (cmd.enable && !st_r.en_d) begin
            st_nxt.out.fault = 1'b0;
        end
        // off unless enabled and fault free
        run = cmd.enable && !st_r.out.fault && !act;
        for (int k = 0; k < 3; k++) begin
            st_nxt.out.hi[k] = run && pptg_pkg::under(tri_pos + st_r.dtt, st_r.lat[k].den,
                                                      st_r.lat[k].num, 64'h0);
            st_nxt.out.lo[k] = run && !pptg_pkg::under(tri_pos, st_r.lat[k].den,
                                        st_r.lat[k].num, st_r.dtt * 64'(st_r.lat[k].den));
        end
        st_nxt.out.amp_en = run;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out = st_r.out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_TP_OFF: assert property (!cmd.enable |=> out.hi == 3'h0 && out.lo == 3'h0 && !out.amp_en)
        else $error("three-phase drives active while disabled");
    AST_TP_HOLD: assert property (out.fault && !(cmd.enable && !st_r.en_d) |=> out.fault)
        else $error("fault cleared without enable rising");
    AST_TP_POL: assert property ((fault_pin == cmd.fault_invert) |=> out.fault && !out.amp_en)
        else $error("active fault input not latched");
    AST_TP_GAP: assert property ((out.hi & out.lo) == 3'h0)
        else $error("high and low side on together");
    AST_TP_MID: assert property (pwm_tick && cmd.value[0] == 16'h0000 |=>
        {st_r.lat[0].num, 1'b0} == {1'b0, st_r.lat[0].den})
        else $error("zero command not at half duty");
    AST_TP_CLIP: assert property (pwm_tick && cmd.scale != 16'h0000 &&
        $signed(cmd.value[0]) >= $signed({1'b0, cmd.scale}) |=> st_r.lat[0].num == st_r.lat[0].den)
        else $error("three-phase command not clipped to scale");
    COV_TP_FAULT: cover property (out.fault ##1 cmd.enable && !st_r.en_d ##1 !out.fault);
endmodule // pptg_tpg

// >>> tb/pptg_drive_model.sv
// Power stage model: fault pin source and shoot-through watch
`timescale 1ns/100ps
module pptg_drive_model (
    input  logic                   core_clk,
    input  pptg_pkg::pptg_tp_out_t tp_out,
    input  logic                   fault_req,
    input  logic                   fault_high,
    output logic                   fault_pin,
    output int                     shoot_cnt
);
    assign fault_pin = fault_req ? fault_high : ~fault_high;
    initial shoot_cnt = 0;
    // both gates on is a short
    always @(posedge core_clk) begin
        if ((tp_out.hi & tp_out.lo) != 3'h0) begin
            shoot_cnt <= shoot_cnt + 1;
        end
    end
endmodule // pptg_drive_model

// >>> tb/pptg_top_test.sv
// Self-checking bench of the pulse generator top
`timescale 1ns/100ps
module pptg_top_test;
    logic                                       core_clk;
    logic                                       sys_rst;
    pptg_pkg::pptg_cfg_t                        cfg;
    pptg_pkg::pptg_ch_cmd_t [pptg_pkg::NCH-1:0] ch_cmd;
    pptg_pkg::pptg_ch_out_t [pptg_pkg::NCH-1:0] ch_out;
    pptg_pkg::pptg_tp_cmd_t                     tp_cmd;
    logic                                       tp_fault_pin;
    pptg_pkg::pptg_tp_out_t                     tp_out;
    logic                                       fault_req;
    logic                                       fault_high;
    int                                         shoot_cnt;
    int                                         errors;
    int                                         tests_run;
    int                                         n_a;
    int                                         n_b;
    int                                         n_c;
    int                                         n_h;
    int                                         n_l;
    int                                         n_r;

    pptg_top i_pptg_top (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .ch_cmd(ch_cmd),
        .ch_out(ch_out), .tp_cmd(tp_cmd), .tp_fault_pin(tp_fault_pin), .tp_out(tp_out));
    pptg_drive_model i_pptg_drive_model (.core_clk(core_clk), .tp_out(tp_out),
        .fault_req(fault_req), .fault_high(fault_high), .fault_pin(tp_fault_pin),
        .shoot_cnt(shoot_cnt));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic int b(input logic x);
        // An unknown level pushes the count that samples it far out of range
        return (x === 1'b1) ? 1 : (x === 1'b0) ? 0 : 100000;
    endfunction

    function automatic logic [31:0] near(input int c, input int e, input int t);
        return (c >= e - t && c <= e + t) ? 32'h1 : 32'h0;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Counts high cycles and rising edges over a window
    task automatic sample(input int n);
        logic p;
        n_a = 0;
        n_b = 0;
        n_c = 0;
        n_h = 0;
        n_l = 0;
        n_r = 0;
        p = ch_out[0].first_signal_output;
        repeat (n) begin
            @(negedge core_clk);
            n_a += b(ch_out[0].first_signal_output);
            n_b += b(ch_out[0].second_signal_output);
            n_c += b(ch_out[1].first_signal_output);
            n_h += b(tp_out.hi[0]) + b(tp_out.hi[1]) + b(tp_out.hi[2]);
            n_l += b(tp_out.lo[0]) + b(tp_out.lo[1]) + b(tp_out.lo[2]);
            n_r += b(ch_out[0].first_signal_output & ~p);
            p = ch_out[0].first_signal_output;
        end
    endtask

    task automatic set_ch(input int i, input logic en, input logic offs, input logic [2:0] ot,
                          input logic [15:0] v, input logic [15:0] sc);
        ch_cmd[i].enable = en;
        ch_cmd[i].offset_mode = offs;
        ch_cmd[i].otype = ot;
        ch_cmd[i].value = v;
        ch_cmd[i].scale = sc;
    endtask

    task automatic t_reset();
        check(32'(ch_out[0].enable_n), 32'h1);
        check(32'(ch_out[0].first_signal_output), 32'h0);
        check(32'(tp_out), 32'h0);
    endtask

    task automatic t_pwm_dir();
        set_ch(0, 1'b1, 1'b0, 3'h1, 16'h0080, 16'h0000);
        cyc(1);
        check(32'(ch_out[0].enable_n), 32'h0);
        cyc(1100); sample(2000);
        check(near(n_a, 1000, 6), 32'h1);
        check(32'(n_b), 32'h0);
        set_ch(0, 1'b1, 1'b0, 3'h1, 16'hFF80, 16'h0000);
        cyc(1100); sample(2000);
        check(near(n_a, 1000, 6), 32'h1);
        check(32'(n_b), 32'(2000));
        set_ch(0, 1'b1, 1'b0, 3'h1, 16'h0300, 16'h0100);
        cyc(1100); sample(2000);
        check(near(n_a, 2000, 2), 32'h1);
        set_ch(0, 1'b1, 1'b0, 3'h1, 16'h0100, 16'h0200);
        cyc(1100); sample(2000);
        check(near(n_a, 1000, 6), 32'h1);
        set_ch(0, 1'b0, 1'b0, 3'h1, 16'h0100, 16'h0200);
        cyc(1);
        check(32'(ch_out[0].enable_n), 32'h1);
        sample(300);
        check(32'(n_a + n_b), 32'h0);
    endtask

    task automatic t_types();
        set_ch(0, 1'b1, 1'b0, 3'h1, 16'h0080, 16'h0000);
        cyc(1100);
        set_ch(0, 1'b1, 1'b0, 3'h4, 16'h0080, 16'h0000);
        sample(2000);
        check(32'(n_a), 32'h0);
        check(near(n_b, 1000, 6), 32'h1);
        set_ch(0, 1'b1, 1'b0, 3'h2, 16'h0080, 16'h0000);
        sample(2000);
        check(near(n_a, 1000, 6), 32'h1);
        check(32'(n_b), 32'h0);
        set_ch(0, 1'b1, 1'b0, 3'h2, 16'hFF80, 16'h0000);
        cyc(1100); sample(2000);
        check(32'(n_a), 32'h0);
        check(near(n_b, 1000, 6), 32'h1);
        cfg.pdm_hz = 25'h01E8480;
        set_ch(0, 1'b1, 1'b0, 3'h3, 16'h0080, 16'h0000);
        cyc(200); sample(2000);
        check(near(n_a, 1000, 20), 32'h1);
        check(near(n_r, 100, 3), 32'h1);
        check(32'(n_b), 32'h0);
    endtask

    task automatic t_offset();
        logic [15:0] ov [3];
        int          oe [3];
        ov = '{16'h0000, 16'hFF00, 16'h0100};
        oe = '{1000, 0, 2000};
        for (int k = 0; k < 3; k++) begin
            set_ch(0, 1'b1, 1'b1, 3'h1, ov[k], 16'h0000);
            set_ch(1, 1'b1, 1'b1, 3'h1, ov[k], 16'h0000);
            cyc(1100); sample(2000);
            check(near(n_a, oe[k], 6), 32'h1);
            check(near(n_c, oe[k], 6), 32'h1);
        end
    endtask

    task automatic t_rate();
        set_ch(0, 1'b1, 1'b0, 3'h1, 16'h0080, 16'h0000);
        cfg.pwm_hz = 18'h00000;
        cyc(1100); sample(6000);
        check(near(n_r, 6, 1), 32'h1);
        cfg.pwm_hz = 18'h30D40;
        cyc(1100); sample(6000);
        check(near(n_r, 6000 * int'(pptg_pkg::PWM_MAX_HZ) / 20000000, 1), 32'h1);
        cfg.pwm_hz = 18'h00000;
    endtask

    task automatic t_three();
        tp_cmd = '{enable: 1'b1, fault_invert: 1'b0, value: {3{16'h0000}}, scale: 16'h0000,
                   dead_ns: 16'h1388};
        cyc(1);
        check(32'(tp_out.amp_en), 32'h1);
        cyc(1100); sample(2000);
        check(near(n_h, 1800, 18), 32'h1);
        check(near(n_l, 1800, 18), 32'h1);
        tp_cmd.dead_ns = 16'h0000;
        tp_cmd.value = {3{16'h0100}};
        tp_cmd.scale = 16'h0200;
        cyc(1100); sample(2000);
        check(near(n_h, 4500, 18), 32'h1);
        check(near(n_l, 1500, 9), 32'h1);
        tp_cmd.value = {3{16'h0300}};
        cyc(1100); sample(2000);
        check(near(n_h, 6000, 6), 32'h1);
        check(near(n_l, 0, 6), 32'h1);
        tp_cmd.value = {3{16'hFF00}};
        tp_cmd.scale = 16'h0000;
        cyc(1100); sample(2000);
        check(near(n_l, 6000, 6), 32'h1);
        tp_cmd.enable = 1'b0;
        cyc(1);
        check(32'(tp_out), 32'h0);
        check(32'(shoot_cnt), 32'h0);
    endtask

    task automatic t_fault();
        tp_cmd = '{enable: 1'b1, fault_invert: 1'b0, value: {3{16'h0000}}, scale: 16'h0000,
                   dead_ns: 16'h1388};
        cyc(100);
        fault_req = 1'b1;
        cyc(1);
        check(32'({tp_out.hi, tp_out.lo, tp_out.amp_en, tp_out.fault}), 32'h1);
        fault_req = 1'b0;
        cyc(20);
        check(32'(tp_out.fault), 32'h1);
        tp_cmd.enable = 1'b0;
        cyc(1);
        tp_cmd.enable = 1'b1;
        cyc(2);
        check(32'(tp_out.fault), 32'h0);
        check(32'(tp_out.amp_en), 32'h1);
        tp_cmd.fault_invert = 1'b1;
        fault_high = 1'b1;
        cyc(10);
        check(32'(tp_out.fault), 32'h0);
        fault_req = 1'b1;
        cyc(1);
        check(32'(tp_out.fault), 32'h1);
        fault_req = 1'b0;
    endtask

    initial begin
        errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        cfg = '0;
        ch_cmd = '0;
        tp_cmd = '0;
        fault_req = 1'b0;
        fault_high = 1'b0;
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
        t_reset();
        t_pwm_dir();
        t_types();
        t_offset();
        t_rate();
        t_three();
        t_fault();
        wrap_up();
    end

    initial begin
        #4_000_000;
        errors++;
        wrap_up();
    end
endmodule // pptg_top_test
